/* inc/icx_pkg.sv */
// How it works
// - Byte words: top 00, 4-bit code, destination at bit 7, 7-bit file address.
// - And, or, xor, complement and move update only the zero flag.
// - Add and subtract (file minus accumulator) update carry, half carry and zero.
// - Increment/decrement set zero; the skip forms change no flag, skip on zero.
// - Rotates go through carry and update only the carry flag.
// - Nibble swap changes no flag and writes the selected destination.
// - Bit words: top 01, 2-bit code, bit index, address; clear or set.
// - Bit tests skip the next word on clear or on set; no flags.
// - One cycle per word; branches and taken skips add a dummy cycle.
// - Literal add, subtract, and, or, xor work on the accumulator with flags.
// - Load literal takes one cycle; the three return forms take two.
// - Standby and watchdog clear words update expiry and power-down flags.
// - A port register is read from its pin levels, not its latch.
// - A write to timer zero clears its prescaler when assigned there.
// - One instruction cycle is four clock periods.
package icx_pkg;
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_CTRL = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOV = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RR = 4'hC;
  localparam logic [3:0] OP_RL = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  localparam logic [7:0] LOW_RET = 8'h08;
  localparam logic [7:0] LOW_INT_RET = 8'h09;
  localparam logic [7:0] LOW_SLEEP = 8'h63;
  localparam logic [7:0] LOW_WDTCLR = 8'h64;
  localparam logic [1:0] BOP_CLR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_TSTC = 2'h2;
  localparam logic [1:0] BOP_TSTS = 2'h3;
  localparam logic [1:0] LOP_LOAD = 2'h0;
  localparam logic [1:0] LOP_RET_LIT = 2'h1;
  localparam logic [2:0] LOP_SUB = 3'h6;
  localparam logic [2:0] LOP_ADD = 3'h7;
  localparam logic [3:0] LOP_OR = 4'h8;
  localparam logic [3:0] LOP_AND = 4'h9;
  localparam logic [3:0] LOP_XOR = 4'hA;
  localparam int DEST_BIT = 7;
  localparam int CALL_BIT = 11;
  localparam logic [6:0] PORT_ADDR = 7'h05;
  localparam logic [6:0] TIMER0_ADDR = 7'h01;
  localparam int STACK_DEPTH = 8;
  localparam logic RST_EXPIRY = 1'b1;
  localparam logic RST_PWRDN = 1'b1;
  localparam int OSC_PER_INSTR = 4;
  localparam logic [10:0] PC_STEP = 11'h001;
  localparam logic [10:0] PC_SKIP = 11'h002;
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } icx_phase_t;
endpackage

/* verilog/icx_core.sv */
`timescale 1ns/100ps
`default_nettype none
module icx_core import icx_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [13:0] INSTR,
  output logic [10:0] PROG_ADDR,
  output logic [6:0] FILE_ADDR,
  input wire logic [7:0] FILE_RDATA,
  output logic [7:0] FILE_WDATA,
  output logic FILE_WE,
  input wire logic [7:0] PORT_PINS,
  input wire logic PRESC_ON_TIMER0,
  output logic PRESCALER_CLEAR,
  output logic [7:0] ACCUM,
  output logic CARRY_FLAG,
  output logic HALF_CARRY_FLAG,
  output logic ZERO_FLAG,
  output logic WATCHDOG_EXPIRY_FLAG,
  output logic POWER_DOWN_FLAG,
  output logic STANDBY_REQ,
  output logic WATCHDOG_CLEAR,
  output logic INT_RETURN
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Returns {carry, half carry, sum}; subtraction passes ~b with ci set.
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic ci);
    logic [4:0] lo;
    logic [8:0] s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    add8 = {s[8], lo[4], s[7:0]};
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  icx_phase_t ph;
  icx_phase_t next_ph;
  logic [13:0] ir;
  logic flush;
  logic [10:0] pc;
  logic [10:0] stack [STACK_DEPTH];
  logic [2:0] sp;
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [7:0] pin_s3;
  logic [7:0] pin_level;

  logic [1:0] grp;
  logic [3:0] op;
  logic dst;
  logic [2:0] bidx;
  logic [6:0] addr;
  logic [7:0] src;
  logic exec;
  logic [7:0] res;
  logic [9:0] arith;
  logic wr_file, wr_acc, upd_z, upd_c, upd_dc;
  logic skip, jump, push, pop, sleep, wdtc, retint;
  logic [10:0] tgt;
  logic [10:0] next_pc;

  assign grp = ir[13:12];
  assign op = ir[11:8];
  assign dst = ir[DEST_BIT];
  assign bidx = ir[9:7];
  assign addr = ir[6:0];
  assign FILE_ADDR = ir[6:0];
  assign PROG_ADDR = pc;
  assign exec = (ph == PH_Q3) && !flush;
  // A port is sampled at its pins so external drive wins over the latch.
  assign src = (addr == PORT_ADDR) ? pin_level : FILE_RDATA;

  // ----------------------------------------------------------------
  // Instruction cycle and fetch
  // ----------------------------------------------------------------
  always_comb begin
    case (ph)
      PH_Q1: next_ph = PH_Q2;
      PH_Q2: next_ph = PH_Q3;
      PH_Q3: next_ph = PH_Q4;
      PH_Q4: next_ph = PH_Q1;
      default: next_ph = PH_Q1;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ph <= PH_Q1;
    end else begin
      ph <= next_ph;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ir <= 14'h0000;
    end else if (ph == PH_Q1) begin
      ir <= INSTR;
    end
  end

  // A level only counts once the two later stages agree.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
      pin_level <= 8'h00;
    end else begin
      pin_s1 <= PORT_PINS;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------------
  always_comb begin
    res = 8'h00;
    arith = 10'h000;
    wr_file = 1'b0;
    wr_acc = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    sleep = 1'b0;
    wdtc = 1'b0;
    retint = 1'b0;
    tgt = pc;
    case (grp)
      GRP_BYTE: begin
        if (op != OP_MISC) begin
          wr_file = dst;
          wr_acc = !dst;
        end
        case (op)
          OP_MISC: begin
            if (dst) begin
              res = ACCUM;
              wr_file = 1'b1;
            end else begin
              case (ir[7:0])
                LOW_RET: pop = 1'b1;
                LOW_INT_RET: begin
                  pop = 1'b1;
                  retint = 1'b1;
                end
                LOW_SLEEP: sleep = 1'b1;
                LOW_WDTCLR: wdtc = 1'b1;
                default: ;
              endcase
            end
          end
          OP_CLR: upd_z = 1'b1;
          OP_SUB, OP_ADD: begin
            arith = (op == OP_ADD) ? add8(src, ACCUM, 1'b0)
                                   : add8(src, ~ACCUM, 1'b1);
            res = arith[7:0];
            upd_z = 1'b1;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          OP_DEC, OP_DECSZ: res = src - 8'h01;
          OP_INC, OP_INCSZ: res = src + 8'h01;
          OP_OR: res = src | ACCUM;
          OP_AND: res = src & ACCUM;
          OP_XOR: res = src ^ ACCUM;
          OP_COM: res = ~src;
          OP_MOV: res = src;
          OP_RL: begin
            res = {src[6:0], CARRY_FLAG};
            arith = {src[7], 9'h000};
            upd_c = 1'b1;
          end
          OP_RR: begin
            res = {CARRY_FLAG, src[7:1]};
            arith = {src[0], 9'h000};
            upd_c = 1'b1;
          end
          OP_SWAP: res = {src[3:0], src[7:4]};
          default: ;
        endcase
        if (op == OP_DEC || op == OP_INC || op == OP_OR || op == OP_AND ||
            op == OP_XOR || op == OP_COM || op == OP_MOV) begin
          upd_z = 1'b1;
        end
        if (op == OP_DECSZ || op == OP_INCSZ) begin
          skip = (res == 8'h00);
        end
      end
      GRP_BIT: begin
        case (ir[11:10])
          BOP_CLR: begin
            res = src & ~bit_mask(bidx);
            wr_file = 1'b1;
          end
          BOP_SET: begin
            res = src | bit_mask(bidx);
            wr_file = 1'b1;
          end
          BOP_TSTC: skip = (src & bit_mask(bidx)) == 8'h00;
          BOP_TSTS: skip = (src & bit_mask(bidx)) != 8'h00;
          default: ;
        endcase
      end
      GRP_CTRL: begin
        jump = 1'b1;
        tgt = ir[10:0];
        push = !ir[CALL_BIT];
      end
      GRP_LIT: begin
        wr_acc = 1'b1;
        res = ir[7:0];
        if (ir[11:10] == LOP_RET_LIT) begin
          pop = 1'b1;
        end else if (ir[11:10] == LOP_LOAD) begin
          wr_acc = 1'b1;
        end else if (ir[11:9] == LOP_ADD || ir[11:9] == LOP_SUB) begin
          arith = (ir[11:9] == LOP_ADD) ? add8(ir[7:0], ACCUM, 1'b0)
                                        : add8(ir[7:0], ~ACCUM, 1'b1);
          res = arith[7:0];
          upd_z = 1'b1;
          upd_c = 1'b1;
          upd_dc = 1'b1;
        end else if (op == LOP_OR || op == LOP_AND || op == LOP_XOR) begin
          res = (op == LOP_OR) ? (ir[7:0] | ACCUM) :
                (op == LOP_AND) ? (ir[7:0] & ACCUM) : (ir[7:0] ^ ACCUM);
          upd_z = 1'b1;
        end else begin
          wr_acc = 1'b0;
        end
      end
      default: ;
    endcase
  end

  always_comb begin
    next_pc = pc + PC_STEP;
    if (pop) begin
      next_pc = stack[sp - 3'h1];
    end else if (jump) begin
      next_pc = tgt;
    end else if (skip) begin
      next_pc = pc + PC_SKIP;
    end
  end

  // ----------------------------------------------------------------
  // Commit at the third clock of each instruction cycle
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ACCUM <= 8'h00;
      CARRY_FLAG <= 1'b0;
      HALF_CARRY_FLAG <= 1'b0;
      ZERO_FLAG <= 1'b0;
    end else if (exec) begin
      if (wr_acc) begin
        ACCUM <= res;
      end
      if (upd_c) begin
        CARRY_FLAG <= arith[9];
      end
      if (upd_dc) begin
        HALF_CARRY_FLAG <= arith[8];
      end
      if (upd_z) begin
        ZERO_FLAG <= (res == 8'h00);
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      FILE_WE <= 1'b0;
      FILE_WDATA <= 8'h00;
      PRESCALER_CLEAR <= 1'b0;
      STANDBY_REQ <= 1'b0;
      WATCHDOG_CLEAR <= 1'b0;
      INT_RETURN <= 1'b0;
    end else begin
      FILE_WE <= exec && wr_file;
      if (exec && wr_file) begin
        FILE_WDATA <= res;
      end
      PRESCALER_CLEAR <= exec && wr_file && (addr == TIMER0_ADDR) &&
                         PRESC_ON_TIMER0;
      STANDBY_REQ <= exec && sleep;
      WATCHDOG_CLEAR <= exec && wdtc;
      INT_RETURN <= exec && retint;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      WATCHDOG_EXPIRY_FLAG <= RST_EXPIRY;
      POWER_DOWN_FLAG <= RST_PWRDN;
    end else if (exec && (sleep || wdtc)) begin
      WATCHDOG_EXPIRY_FLAG <= 1'b1;
      POWER_DOWN_FLAG <= wdtc;
    end
  end

  // The dummy cycle holds the counter, so a skip steps it by two at once.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pc <= 11'h000;
      flush <= 1'b0;
      sp <= 3'h0;
    end else if (ph == PH_Q3) begin
      if (flush) begin
        flush <= 1'b0;
      end else begin
        pc <= next_pc;
        flush <= skip || jump || pop;
        if (push) begin
          sp <= sp + 3'h1;
        end else if (pop) begin
          sp <= sp - 3'h1;
        end
      end
    end
  end

  // The stack wraps silently; overflow overwrites the oldest entry.
  always_ff @(posedge REF_CLK) begin
    if (exec && push) begin
      stack[sp] <= pc + PC_STEP;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  sequence instr_cycle_s;
    ph == PH_Q1 ##1 ph == PH_Q2 ##1 ph == PH_Q3 ##1 ph == PH_Q4;
  endsequence

  sequence dummy_cycle_s;
    flush ##1 (flush && !FILE_WE)[*3] ##1 (!flush && !FILE_WE);
  endsequence

  phase_order_a: assert property (
    ph == PH_Q1 |-> instr_cycle_s ##1 ph == PH_Q1)
    else $error("instruction cycle is not four clocks");

  dummy_cycle_a: assert property (
    exec && (skip || jump || pop) |=> dummy_cycle_s)
    else $error("two-cycle word without a dummy cycle");

  accum_dest_a: assert property (
    exec && grp == GRP_BYTE && op != OP_MISC && !dst
    |=> !FILE_WE && ACCUM == $past(res))
    else $error("accumulator destination not honoured");

  logic_zero_a: assert property (
    exec && grp == GRP_BYTE && (op == OP_AND || op == OP_XOR)
    |=> ZERO_FLAG == ($past(res) == 8'h00) &&
        CARRY_FLAG == $past(CARRY_FLAG))
    else $error("logic op flag update wrong");

  add_carry_a: assert property (
    exec && grp == GRP_BYTE && op == OP_ADD && !dst
    |=> {CARRY_FLAG, ACCUM} == {1'b0, $past(src)} + {1'b0, $past(ACCUM)})
    else $error("add result or carry wrong");

  skip_zero_a: assert property (
    exec && grp == GRP_BYTE && op == OP_INCSZ && src == 8'hFF
    |=> flush && PROG_ADDR == $past(pc) + PC_SKIP)
    else $error("increment skip not taken");

  rotate_carry_a: assert property (
    exec && grp == GRP_BYTE && op == OP_RL
    |=> CARRY_FLAG == $past(src[7]) && ZERO_FLAG == $past(ZERO_FLAG))
    else $error("rotate carry wrong");

  swap_data_a: assert property (
    exec && grp == GRP_BYTE && op == OP_SWAP && dst
    |=> FILE_WE && FILE_WDATA == {$past(src[3:0]), $past(src[7:4])})
    else $error("nibble swap wrong");

  bit_set_a: assert property (
    exec && grp == GRP_BIT && ir[11:10] == BOP_SET
    |=> FILE_WE && FILE_WDATA == ($past(src) | bit_mask($past(bidx))))
    else $error("bit set wrong");

  call_target_a: assert property (
    exec && grp == GRP_CTRL |=> flush && PROG_ADDR == $past(ir[10:0]))
    else $error("branch target wrong");

  standby_flags_a: assert property (
    exec && grp == GRP_BYTE && op == OP_MISC && ir[7:0] == LOW_SLEEP
    |=> STANDBY_REQ && WATCHDOG_EXPIRY_FLAG && !POWER_DOWN_FLAG)
    else $error("standby flags wrong");

  presc_clear_a: assert property (
    exec && wr_file && addr == TIMER0_ADDR && PRESC_ON_TIMER0
    |=> PRESCALER_CLEAR ##1 !PRESCALER_CLEAR)
    else $error("prescaler clear missing");

endmodule // icx_core
`default_nettype wire

/* tb/instr_decode_execute_14bit_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t got %h expected %h", $time, (a), (e)); end end
module instr_decode_execute_14bit_test import icx_pkg::*; ;
  logic REF_CLK, RESETN, FILE_WE, PRESC_ON_TIMER0, PRESCALER_CLEAR;
  logic CARRY_FLAG, HALF_CARRY_FLAG, ZERO_FLAG, WATCHDOG_EXPIRY_FLAG;
  logic POWER_DOWN_FLAG, STANDBY_REQ, WATCHDOG_CLEAR, INT_RETURN;
  logic [13:0] INSTR;
  logic [10:0] PROG_ADDR;
  logic [6:0] FILE_ADDR;
  logic [7:0] FILE_RDATA, FILE_WDATA, PORT_PINS, ACCUM;
  logic [13:0] prog [0:63];
  logic [7:0] fmem [0:127];
  logic [15:0] cyc, we31;
  logic [3:0] n_pc, n_ir, n_sb, n_wd;
  int failures = 0;
  int num_checks = 0;

  icx_core dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .INSTR(INSTR),
    .PROG_ADDR(PROG_ADDR), .FILE_ADDR(FILE_ADDR), .FILE_RDATA(FILE_RDATA),
    .FILE_WDATA(FILE_WDATA), .FILE_WE(FILE_WE), .PORT_PINS(PORT_PINS),
    .PRESC_ON_TIMER0(PRESC_ON_TIMER0), .PRESCALER_CLEAR(PRESCALER_CLEAR),
    .ACCUM(ACCUM), .CARRY_FLAG(CARRY_FLAG),
    .HALF_CARRY_FLAG(HALF_CARRY_FLAG), .ZERO_FLAG(ZERO_FLAG),
    .WATCHDOG_EXPIRY_FLAG(WATCHDOG_EXPIRY_FLAG),
    .POWER_DOWN_FLAG(POWER_DOWN_FLAG), .STANDBY_REQ(STANDBY_REQ),
    .WATCHDOG_CLEAR(WATCHDOG_CLEAR), .INT_RETURN(INT_RETURN));

  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end

  // ----------------------------------------------------------------
  // Memories and monitors
  // ----------------------------------------------------------------
  // Both memories answer one clock after the address moves, which still
  // lands before the fetch edge and inside the read phase.
  always @(posedge REF_CLK) begin
    INSTR <= prog[PROG_ADDR[5:0]];
    FILE_RDATA <= fmem[FILE_ADDR];
    if (FILE_WE) begin
      fmem[FILE_ADDR] <= FILE_WDATA;
    end
    cyc <= RESETN ? cyc + 16'h0001 : 16'h0000;
    if (!RESETN) begin
      {n_pc, n_ir, n_sb, n_wd} <= 16'h0000;
      we31 <= 16'hFFFF;
    end else begin
      if (FILE_WE && FILE_ADDR == 7'h31) begin
        we31 <= cyc;
      end
      n_pc <= n_pc + {3'h0, PRESCALER_CLEAR};
      n_ir <= n_ir + {3'h0, INT_RETURN};
      n_sb <= n_sb + {3'h0, STANDBY_REQ};
      n_wd <= n_wd + {3'h0, WATCHDOG_CLEAR};
    end
  end

  function automatic logic [13:0] bw(logic [3:0] o, logic d, logic [6:0] f);
    return {2'h0, o, d, f};
  endfunction
  function automatic logic [13:0] bb(logic [1:0] o, logic [2:0] b,
                                     logic [6:0] f);
    return {2'h1, o, b, f};
  endfunction
  function automatic logic [13:0] lw(logic [3:0] c, logic [7:0] k);
    return {2'h3, c, k};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic rst(input logic presc);
    @(posedge REF_CLK);
    RESETN <= 1'b0;
    PRESC_ON_TIMER0 <= presc;
    repeat (16) @(posedge REF_CLK);
    RESETN <= 1'b1;
  endtask

  task automatic fill(input logic [13:0] w);
    for (int i = 0; i < 64; i++) begin
      prog[i] = w;
    end
    for (int i = 0; i < 128; i++) begin
      fmem[i] = 8'h5A;
    end
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge REF_CLK);
    @(negedge REF_CLK);
  endtask

  // Mode m is {flags preset to 1, skip expected, prescaler on timer
  // zero, prescaler pulse expected}. Word 4 is lost when a skip is taken.
  task automatic op1(input logic [13:0] ins, input logic [7:0] w0, f0,
                     input logic [7:0] ew, ef, input logic [2:0] fl,
                     input logic [3:0] m);
    fill(14'h0000);
    fmem[ins[6:0]] = f0;
    if (m[3]) begin
      prog[0] = lw(4'h0, 8'h01);
      prog[1] = lw(4'hF, 8'hFF);
    end
    prog[2] = lw(4'h0, w0);
    prog[3] = ins;
    prog[4] = bw(OP_MISC, 1'h1, 7'h30);
    prog[5] = bw(OP_MISC, 1'h1, 7'h31);
    prog[6] = 14'h2806;
    rst(m[1]);
    run(40);
    `CHK(ACCUM, ew)
    `CHK(fmem[ins[6:0]], ef)
    `CHK({CARRY_FLAG, HALF_CARRY_FLAG, ZERO_FLAG}, fl)
    `CHK(fmem[7'h30], m[2] ? 8'h5A : ew)
    `CHK(we31, 16'h0017)
    `CHK(n_pc, {3'h0, m[0]})
    $display("word %h done", ins);
  endtask

  // Every word that must never run stores to 0x32.
  task automatic ctl_flow;
    fill(bw(OP_MISC, 1'h1, 7'h32));
    prog[0] = 14'h2008;
    prog[8] = lw(4'h4, 8'h77);
    prog[1] = 14'h2804;
    prog[4] = 14'h200A;
    prog[10] = 14'h200C;
    prog[12] = {6'h00, LOW_INT_RET};
    prog[11] = {6'h00, LOW_RET};
    prog[5] = bw(OP_MISC, 1'h1, 7'h31);
    prog[6] = 14'h2806;
    rst(1'h0);
    run(80);
    `CHK(we31, 16'h003B)
    `CHK(fmem[7'h31], 8'h77)
    `CHK(fmem[7'h32], 8'h5A)
    `CHK(n_ir, 4'h1)
    `CHK(PROG_ADDR, 11'h006)
    $display("control flow done");
  endtask

  task automatic power_flags;
    fill(14'h0000);
    prog[0] = {6'h00, LOW_SLEEP};
    prog[1] = 14'h2801;
    rst(1'h0);
    @(negedge REF_CLK);
    `CHK({WATCHDOG_EXPIRY_FLAG, POWER_DOWN_FLAG}, 2'h3)
    `CHK(PROG_ADDR, 11'h000)
    run(20);
    `CHK({WATCHDOG_EXPIRY_FLAG, POWER_DOWN_FLAG}, 2'h2)
    `CHK(n_sb, 4'h1)
    prog[1] = {6'h00, LOW_WDTCLR};
    prog[2] = 14'h2802;
    rst(1'h0);
    run(20);
    `CHK({WATCHDOG_EXPIRY_FLAG, POWER_DOWN_FLAG}, 2'h3)
    `CHK(n_wd, 4'h1)
    $display("power flags done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    RESETN = 1'b0;
    PORT_PINS = 8'h3C;
    PRESC_ON_TIMER0 = 1'b0;
    power_flags();
    ctl_flow();
    op1(bw(OP_ADD,1'h1,7'h2),8'h0F,8'h01,8'h0F,8'h10,3'h2,4'h0);
    op1(bw(OP_ADD,1'h0,7'h2),8'h80,8'h80,8'h00,8'h80,3'h5,4'h0);
    op1(bw(OP_SUB,1'h0,7'h2),8'h01,8'h10,8'h0F,8'h10,3'h4,4'h8);
    op1(bw(OP_SUB,1'h1,7'h2),8'h20,8'h10,8'h20,8'hF0,3'h2,4'h0);
    op1(bw(OP_AND,1'h0,7'h2),8'hF0,8'h3C,8'h30,8'h3C,3'h6,4'h8);
    op1(bw(OP_OR,1'h1,7'h2),8'h00,8'h00,8'h00,8'h00,3'h1,4'h0);
    op1(bw(OP_XOR,1'h0,7'h2),8'hFF,8'h0F,8'hF0,8'h0F,3'h6,4'h8);
    op1(bw(OP_COM,1'h1,7'h2),8'h11,8'hFF,8'h11,8'h00,3'h7,4'h8);
    op1(bw(OP_INC,1'h1,7'h2),8'h11,8'hFF,8'h11,8'h00,3'h1,4'h0);
    op1(bw(OP_DEC,1'h0,7'h2),8'h11,8'h05,8'h04,8'h05,3'h6,4'h8);
    op1(bw(OP_INCSZ,1'h1,7'h2),8'h11,8'hFF,8'h11,8'h00,3'h0,4'h4);
    op1(bw(OP_INCSZ,1'h0,7'h2),8'h11,8'h20,8'h21,8'h20,3'h7,4'h8);
    op1(bw(OP_DECSZ,1'h0,7'h2),8'h11,8'h01,8'h00,8'h01,3'h0,4'h4);
    op1(bw(OP_RL,1'h1,7'h2),8'h11,8'h40,8'h11,8'h81,3'h3,4'h8);
    op1(bw(OP_RR,1'h0,7'h2),8'h11,8'h01,8'h00,8'h01,3'h4,4'h0);
    op1(bw(OP_SWAP,1'h1,7'h2),8'h11,8'hC3,8'h11,8'h3C,3'h7,4'h8);
    op1(bw(OP_CLR,1'h1,7'h2),8'h11,8'h77,8'h11,8'h00,3'h1,4'h0);
    op1(bw(OP_CLR,1'h0,7'h2),8'h11,8'h77,8'h00,8'h77,3'h1,4'h0);
    op1(bw(OP_MISC,1'h1,7'h2),8'h99,8'h00,8'h99,8'h99,3'h7,4'h8);
    op1(bw(OP_MISC,1'h0,7'h20),8'h11,8'h66,8'h11,8'h66,3'h0,4'h0);
    op1(bb(BOP_CLR,3'h3,7'h2),8'h11,8'hFF,8'h11,8'hF7,3'h7,4'h8);
    op1(bb(BOP_TSTC,3'h0,7'h2),8'h11,8'hFE,8'h11,8'hFE,3'h0,4'h4);
    op1(bb(BOP_TSTC,3'h0,7'h2),8'h11,8'h01,8'h11,8'h01,3'h0,4'h0);
    op1(bb(BOP_TSTS,3'h7,7'h2),8'h11,8'h80,8'h11,8'h80,3'h0,4'h4);
    op1(lw(4'hE,8'h0F),8'h01,8'h5A,8'h10,8'h5A,3'h2,4'h0);
    op1(lw(4'hF,8'hFF),8'h01,8'h5A,8'h00,8'h5A,3'h7,4'h0);
    op1(lw(4'hC,8'h10),8'h01,8'h5A,8'h0F,8'h5A,3'h4,4'h0);
    op1(lw(4'hD,8'h01),8'h02,8'h5A,8'hFF,8'h5A,3'h0,4'h8);
    op1(lw(4'h9,8'h0F),8'hF0,8'h5A,8'h00,8'h5A,3'h1,4'h0);
    op1(lw(4'h8,8'h0F),8'h30,8'h5A,8'h3F,8'h5A,3'h6,4'h8);
    op1(lw(4'hA,8'hFF),8'hFF,8'h5A,8'h00,8'h5A,3'h1,4'h0);
    op1(lw(4'h3,8'h12),8'h11,8'h5A,8'h12,8'h5A,3'h7,4'h8);
    op1(bw(OP_MOV,1'h0,7'h5),8'h11,8'hC3,8'h3C,8'hC3,3'h0,4'h0);
    op1(bw(OP_INC,1'h1,7'h5),8'h11,8'hC3,8'h11,8'h3D,3'h0,4'h0);
    op1(bw(OP_CLR,1'h1,7'h1),8'h11,8'h77,8'h11,8'h00,3'h1,4'h3);
    op1(bw(OP_MOV,1'h0,7'h1),8'h11,8'h77,8'h77,8'h77,3'h0,4'h2);
    op1(bb(BOP_SET,3'h0,7'h1),8'h11,8'h00,8'h11,8'h01,3'h0,4'h3);
    op1(bw(OP_CLR,1'h1,7'h1),8'h11,8'h77,8'h11,8'h00,3'h1,4'h0);
    end_of_test();
  end
endmodule // instr_decode_execute_14bit_test
`default_nettype wire
